// File: design/hall_dsp_pkg.sv
// Shared constants, types and helper functions of the field processing path.
// Assumes a single 50 MHz clock and an AXI4-Lite register map of 32-bit words.
package hall_dsp_pkg;

  // ==========================================================================
  // Timing
  localparam int CLK_HZ = 50_000_000;
  localparam int UPDATE_HZ = 16_000;
  localparam int TICK_CYCLES = CLK_HZ / UPDATE_HZ;

  // ==========================================================================
  // Register map (byte addresses)
  localparam int ADDR_W = 8;
  localparam logic [7:0] SPAN_ADDR = 8'h00;
  localparam logic [7:0] GAIN_ADDR = 8'h04;
  localparam logic [7:0] SHIFT_ADDR = 8'h08;
  localparam logic [7:0] SMOOTH_ADDR = 8'h0C;
  localparam logic [7:0] FLOOR_ADDR = 8'h10;
  localparam logic [7:0] CEIL_ADDR = 8'h14;
  localparam logic [7:0] RESULT_ADDR = 8'h18;
  localparam logic [7:0] IRQ_STAT_ADDR = 8'h1C;
  localparam logic [7:0] IRQ_MASK_ADDR = 8'h20;
  localparam logic [7:0] DIAG_ADDR = 8'h24;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  // ==========================================================================
  // Reset values
  localparam logic [1:0] SPAN_RST = 2'h1;
  localparam logic [14:0] GAIN_RST = 15'h5000;
  localparam logic [14:0] SHIFT_RST = 15'h4000;
  localparam logic [2:0] SMOOTH_RST = 3'h3;
  localparam logic [5:0] FLOOR_RST = 6'h00;
  localparam logic [5:0] CEIL_RST = 6'h3F;
  localparam logic [3:0] MASK_RST = 4'h0;

  // ==========================================================================
  // Arithmetic
  localparam logic signed [15:0] GAIN_BIAS = 16'sh4000;
  localparam int GAIN_FRAC = 12;
  localparam logic signed [15:0] SHIFT_BIAS = 16'sh4000;
  localparam logic [9:0] CLAMP_FILL = 10'h3FF;
  localparam logic [9:0] CLAMP_ZERO = 10'h000;
  localparam logic signed [31:0] OUT_MAX = 32'sh0000_FFFF;
  localparam logic [2:0] LP_BYPASS = 3'h7;
  localparam int LP_FRAC = 16;
  localparam int COEF_SHIFT = 8;

  // ==========================================================================
  // Span codes and one-hot range select
  localparam logic [1:0] SPAN_HIGH = 2'h0;
  localparam logic [1:0] SPAN_MID = 2'h1;
  localparam logic [1:0] SPAN_UNUSED = 2'h2;
  localparam logic [1:0] SPAN_LOW = 2'h3;
  typedef enum logic [2:0] {
    RANGE_LOW = 3'h1,
    RANGE_MID = 3'h2,
    RANGE_HIGH = 3'h4
  } range_t;

  // Status nibble and interrupt bit positions
  localparam int ST_OV = 0;
  localparam int ST_ECC_FIX = 1;
  localparam int ST_ECC_FAIL = 2;
  localparam int ST_CLAMP = 3;
  localparam int NIB_W = 4;

  function automatic range_t span_decode(input logic [1:0] code);
    case (code)
      SPAN_LOW: span_decode = RANGE_LOW;
      SPAN_HIGH: span_decode = RANGE_HIGH;
      default: span_decode = RANGE_MID;
    endcase
  endfunction

  // Single-pole weights, about 256 * 2 * pi * fc / 16 kHz
  function automatic logic [8:0] lp_coef(input logic [2:0] code);
    case (code)
      3'h0: lp_coef = 9'h008;
      3'h1: lp_coef = 9'h018;
      3'h2: lp_coef = 9'h02C;
      3'h3: lp_coef = 9'h040;
      3'h4: lp_coef = 9'h056;
      3'h5: lp_coef = 9'h06E;
      default: lp_coef = 9'h08C;
    endcase
  endfunction

  function automatic logic [15:0] lower_limit(input logic [5:0] code);
    lower_limit = {code, CLAMP_ZERO};
  endfunction

  function automatic logic [15:0] upper_limit(input logic [5:0] code);
    upper_limit = {code, CLAMP_FILL};
  endfunction

  function automatic logic [15:0] sat16(input logic signed [31:0] v);
    if (v < 0) begin
      sat16 = 16'h0000;
    end else if (v > OUT_MAX) begin
      sat16 = 16'hFFFF;
    end else begin
      sat16 = v[15:0];
    end
  endfunction

endpackage

// File: design/smooth_link_if.sv
// Link between the processing core and its input smoothing filter.
// Assumes both ends share the core clock; tick is a one-cycle enable.
`timescale 1ns/1ps
interface smooth_link_if #(parameter int W = 16);
  logic tick;
  logic [2:0] code;
  logic signed [W-1:0] raw;
  logic signed [W-1:0] filt;
  logic filt_valid;
  modport core (output tick, output code, output raw, input filt, input filt_valid);
  modport filter (input tick, input code, input raw, output filt, output filt_valid);
endinterface

// File: design/lowpass_smoother.sv
// Single-pole smoothing filter on the raw field samples, one step per tick.
// Assumes raw is stable in the tick cycle; result appears one cycle later.
`timescale 1ns/1ps
module lowpass_smoother #(
  parameter int W = 16
) (
  // Clock and reset
  input wire logic clk,
  input wire logic sys_rst,
  // Sample link
  smooth_link_if.filter lnk
);
  localparam int AW = W + hall_dsp_pkg::LP_FRAC;
  localparam int HALF = 1 << (hall_dsp_pkg::LP_FRAC - 1);

  logic signed [AW-1:0] acc_q;
  logic signed [AW:0] diff;
  logic signed [AW+10:0] step;
  logic signed [AW-1:0] acc_d;
  logic signed [AW-1:0] rnd;

  // ==========================================================================
  // Update
  always_comb begin
    diff = {lnk.raw[W-1], lnk.raw, {hall_dsp_pkg::LP_FRAC{1'b0}}} - {acc_q[AW-1], acc_q};
    step = (diff * $signed({1'b0, hall_dsp_pkg::lp_coef(lnk.code)})) >>> hall_dsp_pkg::COEF_SHIFT;
    acc_d = acc_q + step[AW-1:0];
    // Rounded read-out keeps the settled value equal to the input
    rnd = acc_d + AW'(HALF); // R6
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      acc_q <= '0;
      lnk.filt <= '0;
      lnk.filt_valid <= 1'b0;
    end else begin
      lnk.filt_valid <= lnk.tick; // R8
      if (lnk.tick) begin
        if (lnk.code == hall_dsp_pkg::LP_BYPASS) begin
          acc_q <= {lnk.raw, {hall_dsp_pkg::LP_FRAC{1'b0}}}; // R7
          lnk.filt <= lnk.raw;
        end else begin
          acc_q <= acc_d; // R7
          lnk.filt <= rnd[AW-1:hall_dsp_pkg::LP_FRAC];
        end
      end
    end
  end

  bypass_passes_a: assert property (@(posedge clk) disable iff (sys_rst) // R7
    (lnk.tick && lnk.code == hall_dsp_pkg::LP_BYPASS) |=> (lnk.filt == $past(lnk.raw)))
    else $error("bypass did not pass the raw sample");

endmodule

// File: design/parity_scrub.sv
// Matrix parity check of the configuration memory image.
// Assumes the image is stable; the last line holds the column parity bits.
`timescale 1ns/1ps
module parity_scrub #(
  parameter int LINES = 8,
  parameter int W = 16
) (
  // Clock and reset
  input wire logic clk,
  input wire logic sys_rst,
  // Memory image, bit W of each line but the last is its row parity
  input wire logic [LINES:0][W:0] image,
  // Results
  output logic fix_q,
  output logic fail_q,
  output logic [7:0] fix_line_q
);
  logic [LINES-1:0] row_err;
  logic [W:0] col_err;
  logic col_sum;
  logic fix;
  logic fail;
  logic [7:0] bad_line;

  // ==========================================================================
  // Row odd parity, column alternating parity, parity column even
  always_comb begin
    row_err = '0;
    col_err = '0;
    bad_line = 8'h00;
    col_sum = 1'b0;
    for (int r = 0; r < LINES; r++) begin
      row_err[r] = ~(^image[r]);
      if (row_err[r]) begin
        bad_line = 8'(r);
      end
    end
    for (int j = 0; j <= W; j++) begin
      col_sum = 1'b0;
      for (int r = 0; r <= LINES; r++) begin
        col_sum = col_sum ^ image[r][j];
      end
      col_err[j] = (j < W) ? (col_sum != j[0]) : col_sum;
    end
    fix = $onehot(row_err) && $onehot(col_err); // R15
    fail = ((|row_err) || (|col_err)) && !fix; // R16
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      fix_q <= 1'b0;
      fix_line_q <= 8'h00;
    end else begin
      fix_q <= fix; // R15
      fix_line_q <= bad_line;
    end
  end

  // Latched until reset: a defective memory never recovers on its own
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      fail_q <= 1'b0;
    end else begin
      fail_q <= fail_q | fail; // R16 R17
    end
  end

  two_lines_fail_a: assert property (@(posedge clk) disable iff (sys_rst) // R16
    ($countones(row_err) > 1) |=> fail_q)
    else $error("two bad lines not flagged as failure");

  single_fix_a: assert property (@(posedge clk) disable iff (sys_rst) // R15
    ($onehot(row_err) && $onehot(col_err)) |=> (fix_q && fail_q == $past(fail_q)))
    else $error("single bit error not treated as correctable");

endmodule

// File: design/hall_field_dsp_path.sv
// Field processing path: smoothing, gain, offset, limiting, clamping, diagnostics.
// Assumes raw samples synchronous to clk and an AXI4-Lite master on the bus.
//
// Overview of operation
// R1: span code 3/1/0 selects 50/100/200 mT range
// R2: span code 2 acts as code 1
// R3: calibrator sets span before offset and gain
// R4: gain is multiplier word minus 16384, over 4096
// R5: offset is shift field minus 16384
// R6: smoothing filter keeps unity DC gain
// R7: 3-bit smoothing code, code 7 bypasses
// R8: new filtered sample at 16 kHz
// R9: out-of-band values held at clamp limits
// R10: lower limit is floor code times 1024
// R11: upper limit is (ceiling+1)*1024-1
// R12: software keeps upper limit above lower limit
// R13: diagnostics reported in a status nibble
// R14: overvoltage sets status bit, output stage off
// R15: one single-bit memory error is corrected; the code flags one in the last (column parity) line as a failure
// R16: second bad line is a failure
// R17: memory failure turns output stage off permanently
// R18: filter, gain, offset, then limit to 16 bits
// R19: limiter saturates at 0 and 65535
`timescale 1ns/1ps
module hall_field_dsp_path #(
  parameter int TICK_CYCLES = hall_dsp_pkg::TICK_CYCLES,
  parameter int LINES = 8,
  parameter int LINE_W = 16
) (
  // Clock and reset
  input wire logic clk,
  input wire logic sys_rst,
  // AXI4-Lite slave
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // Field converter and supply monitor
  input wire logic signed [15:0] adc_value,
  input wire logic overvoltage_in,
  output logic [2:0] range_sel,
  // Configuration memory image
  input wire logic [LINES:0][LINE_W:0] eeprom_image,
  // Protocol stage
  output logic [15:0] out_value,
  output logic [3:0] status_nibble,
  output logic out_valid,
  output logic od_stage_off,
  // Interrupt
  output logic irq
);
  localparam int TICK_W = $clog2(TICK_CYCLES + 1);
  localparam int TICK_LAST = TICK_CYCLES - 1;

  logic [1:0] span_q;
  logic [14:0] gain_q;
  logic [14:0] shift_q;
  logic [2:0] smooth_q;
  logic [5:0] floor_q;
  logic [5:0] ceil_q;
  logic [3:0] mask_q;
  logic [3:0] irq_stat_q;
  logic [3:0] irq_stat_d;
  logic [TICK_W-1:0] tick_cnt_q;
  logic tick;
  logic ecc_fix;
  logic ecc_fail;
  logic [7:0] fix_line;
  logic ov_q;
  logic ecc_fail_seen_q;
  logic clamp_q;
  logic signed [31:0] prod_q;
  logic p1_valid_q;
  logic signed [15:0] gain_s;
  logic signed [31:0] sum;
  logic [15:0] limited;
  logic [15:0] lo_lim;
  logic [15:0] hi_lim;
  logic [15:0] clamped;
  logic clamp_hit;
  logic [3:0] events;

  smooth_link_if #(.W(16)) lnk ();

  // ==========================================================================
  // Update-rate divider
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      tick_cnt_q <= '0;
    end else if (tick) begin
      tick_cnt_q <= '0;
    end else begin
      tick_cnt_q <= tick_cnt_q + 1'b1;
    end
  end
  assign tick = (tick_cnt_q == TICK_W'(TICK_LAST)); // R8

  // ==========================================================================
  // Submodules
  assign lnk.tick = tick;
  assign lnk.code = smooth_q;
  assign lnk.raw = adc_value;

  lowpass_smoother #(.W(16)) u_smooth (
    .clk(clk),
    .sys_rst(sys_rst),
    .lnk(lnk)
  );

  parity_scrub #(.LINES(LINES), .W(LINE_W)) u_scrub (
    .clk(clk),
    .sys_rst(sys_rst),
    .image(eeprom_image),
    .fix_q(ecc_fix),
    .fail_q(ecc_fail),
    .fix_line_q(fix_line)
  );

  assign range_sel = hall_dsp_pkg::span_decode(span_q); // R1 R2

  // ==========================================================================
  // Gain, offset, limiter, clamp
  assign gain_s = $signed({1'b0, gain_q}) - hall_dsp_pkg::GAIN_BIAS; // R4

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      prod_q <= '0;
      p1_valid_q <= 1'b0;
    end else begin
      p1_valid_q <= lnk.filt_valid; // R18
      if (lnk.filt_valid) begin
        prod_q <= lnk.filt * gain_s; // R4
      end
    end
  end

  always_comb begin
    sum = (prod_q >>> hall_dsp_pkg::GAIN_FRAC)
          + 32'($signed({1'b0, shift_q}) - hall_dsp_pkg::SHIFT_BIAS); // R5 R18
    limited = hall_dsp_pkg::sat16(sum); // R19
    lo_lim = hall_dsp_pkg::lower_limit(floor_q); // R10
    hi_lim = hall_dsp_pkg::upper_limit(ceil_q); // R11
    clamp_hit = 1'b0;
    clamped = limited;
    if (limited < lo_lim) begin
      clamped = lo_lim; // R9
      clamp_hit = 1'b1;
    end else if (limited > hi_lim) begin
      clamped = hi_lim; // R9
      clamp_hit = 1'b1;
    end
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      out_value <= 16'h0000;
      out_valid <= 1'b0;
      clamp_q <= 1'b0;
    end else begin
      out_valid <= p1_valid_q;
      if (p1_valid_q) begin
        out_value <= clamped; // R18
        clamp_q <= clamp_hit;
      end
    end
  end

  // ==========================================================================
  // Diagnostics
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      ov_q <= 1'b0;
      ecc_fail_seen_q <= 1'b0;
    end else begin
      ov_q <= overvoltage_in;
      ecc_fail_seen_q <= ecc_fail;
    end
  end

  assign status_nibble = {clamp_q, ecc_fail, ecc_fix, ov_q}; // R13 R14
  assign od_stage_off = ov_q | ecc_fail; // R14 R17

  // ==========================================================================
  // Interrupts: sticky, cleared by reading, a new event wins over the clear
  assign events = {clamp_hit & p1_valid_q, ecc_fail & ~ecc_fail_seen_q,
                   ecc_fix, overvoltage_in & ~ov_q};

  always_comb begin
    irq_stat_d = irq_stat_q;
    if (s_axi_arvalid && s_axi_arready && s_axi_araddr == hall_dsp_pkg::IRQ_STAT_ADDR) begin
      irq_stat_d = 4'h0;
    end
    irq_stat_d = irq_stat_d | events;
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      irq_stat_q <= 4'h0;
    end else begin
      irq_stat_q <= irq_stat_d;
    end
  end
  assign irq = |(irq_stat_q & mask_q);

  // ==========================================================================
  // AXI4-Lite write channel; address and data taken in either order
  logic aw_held_q;
  logic w_held_q;
  logic [7:0] waddr_q;
  logic [31:0] wdata_q;
  logic [3:0] wstrb_q;
  logic do_write;
  logic [31:0] wmask;

  assign s_axi_awready = !aw_held_q && !s_axi_bvalid;
  assign s_axi_wready = !w_held_q && !s_axi_bvalid;
  assign do_write = aw_held_q && w_held_q && !s_axi_bvalid;
  assign wmask = {{8{wstrb_q[3]}}, {8{wstrb_q[2]}}, {8{wstrb_q[1]}}, {8{wstrb_q[0]}}};

  function automatic logic [31:0] merge(input logic [31:0] old);
    merge = (old & ~wmask) | (wdata_q & wmask);
  endfunction

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      aw_held_q <= 1'b0;
      w_held_q <= 1'b0;
      waddr_q <= 8'h00;
      wdata_q <= 32'h0000_0000;
      wstrb_q <= 4'h0;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        aw_held_q <= 1'b1;
        waddr_q <= s_axi_awaddr;
      end else if (do_write) begin
        aw_held_q <= 1'b0;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_held_q <= 1'b1;
        wdata_q <= s_axi_wdata;
        wstrb_q <= s_axi_wstrb;
      end else if (do_write) begin
        w_held_q <= 1'b0;
      end
    end
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= hall_dsp_pkg::RESP_OKAY;
    end else if (do_write) begin
      s_axi_bvalid <= 1'b1;
      case (waddr_q)
        hall_dsp_pkg::SPAN_ADDR, hall_dsp_pkg::GAIN_ADDR, hall_dsp_pkg::SHIFT_ADDR,
        hall_dsp_pkg::SMOOTH_ADDR, hall_dsp_pkg::FLOOR_ADDR, hall_dsp_pkg::CEIL_ADDR,
        hall_dsp_pkg::IRQ_MASK_ADDR: s_axi_bresp <= hall_dsp_pkg::RESP_OKAY;
        default: s_axi_bresp <= hall_dsp_pkg::RESP_SLVERR;
      endcase
    end else if (s_axi_bvalid && s_axi_bready) begin
      s_axi_bvalid <= 1'b0;
    end
  end

  // Configuration registers; limits are trusted to be ordered by software
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      span_q <= hall_dsp_pkg::SPAN_RST;
      gain_q <= hall_dsp_pkg::GAIN_RST;
      shift_q <= hall_dsp_pkg::SHIFT_RST;
      smooth_q <= hall_dsp_pkg::SMOOTH_RST;
      floor_q <= hall_dsp_pkg::FLOOR_RST;
      ceil_q <= hall_dsp_pkg::CEIL_RST;
      mask_q <= hall_dsp_pkg::MASK_RST;
    end else if (do_write) begin
      case (waddr_q)
        hall_dsp_pkg::SPAN_ADDR: span_q <= 2'(merge({30'h0, span_q}));
        hall_dsp_pkg::GAIN_ADDR: gain_q <= 15'(merge({17'h0, gain_q}));
        hall_dsp_pkg::SHIFT_ADDR: shift_q <= 15'(merge({17'h0, shift_q}));
        hall_dsp_pkg::SMOOTH_ADDR: smooth_q <= 3'(merge({29'h0, smooth_q}));
        hall_dsp_pkg::FLOOR_ADDR: floor_q <= 6'(merge({26'h0, floor_q}));
        hall_dsp_pkg::CEIL_ADDR: ceil_q <= 6'(merge({26'h0, ceil_q}));
        hall_dsp_pkg::IRQ_MASK_ADDR: mask_q <= 4'(merge({28'h0, mask_q}));
        default: mask_q <= mask_q;
      endcase
    end
  end

  // ==========================================================================
  // AXI4-Lite read channel
  assign s_axi_arready = !s_axi_rvalid;

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h0000_0000;
      s_axi_rresp <= hall_dsp_pkg::RESP_OKAY;
    end else if (s_axi_arvalid && s_axi_arready) begin
      s_axi_rvalid <= 1'b1;
      s_axi_rresp <= hall_dsp_pkg::RESP_OKAY;
      case (s_axi_araddr)
        hall_dsp_pkg::SPAN_ADDR: s_axi_rdata <= {30'h0, span_q};
        hall_dsp_pkg::GAIN_ADDR: s_axi_rdata <= {17'h0, gain_q};
        hall_dsp_pkg::SHIFT_ADDR: s_axi_rdata <= {17'h0, shift_q};
        hall_dsp_pkg::SMOOTH_ADDR: s_axi_rdata <= {29'h0, smooth_q};
        hall_dsp_pkg::FLOOR_ADDR: s_axi_rdata <= {26'h0, floor_q};
        hall_dsp_pkg::CEIL_ADDR: s_axi_rdata <= {26'h0, ceil_q};
        hall_dsp_pkg::RESULT_ADDR: s_axi_rdata <= {12'h0, status_nibble, out_value};
        hall_dsp_pkg::IRQ_STAT_ADDR: s_axi_rdata <= {28'h0, irq_stat_q};
        hall_dsp_pkg::IRQ_MASK_ADDR: s_axi_rdata <= {28'h0, mask_q};
        hall_dsp_pkg::DIAG_ADDR: s_axi_rdata <= {20'h0, od_stage_off, range_sel, fix_line};
        default: begin
          s_axi_rdata <= 32'h0000_0000;
          s_axi_rresp <= hall_dsp_pkg::RESP_SLVERR;
        end
      endcase
    end else if (s_axi_rvalid && s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
    end
  end

  // ==========================================================================
  // Checks
  span_unused_a: assert property (@(posedge clk) disable iff (sys_rst) // R2
    (span_q == hall_dsp_pkg::SPAN_UNUSED) |-> (range_sel == hall_dsp_pkg::RANGE_MID))
    else $error("unused span code not mapped to mid range");
  span_low_a: assert property (@(posedge clk) disable iff (sys_rst) // R1
    (span_q == hall_dsp_pkg::SPAN_LOW) |-> (range_sel == hall_dsp_pkg::RANGE_LOW))
    else $error("span code 3 not mapped to low range");
  tick_period_a: assert property (@(posedge clk) disable iff (sys_rst) // R8
    tick |=> (!tick && tick_cnt_q == '0))
    else $error("update tick spacing wrong");
  pipe_order_a: assert property (@(posedge clk) disable iff (sys_rst) // R18
    lnk.filt_valid |-> ##2 out_valid)
    else $error("processed sample not delivered two cycles after filter");
  clamp_band_a: assert property (@(posedge clk) disable iff (sys_rst) // R9
    $rose(out_valid) |-> (out_value >= $past(lo_lim) && out_value <= $past(hi_lim)))
    else $error("output outside clamp band");
  no_wrap_a: assert property (@(posedge clk) disable iff (sys_rst) // R19
    (p1_valid_q && sum < 0 && floor_q == '0) |=> (out_value == 16'h0000))
    else $error("negative result not saturated to zero");
  gain_apply_a: assert property (@(posedge clk) disable iff (sys_rst) // R4
    (lnk.filt_valid && gain_q == hall_dsp_pkg::GAIN_RST)
      |=> (prod_q == 32'($past(lnk.filt)) <<< hall_dsp_pkg::GAIN_FRAC))
    else $error("unity multiplier word did not give unity gain");
  ov_off_a: assert property (@(posedge clk) disable iff (sys_rst) // R14
    overvoltage_in |=> (od_stage_off && status_nibble[hall_dsp_pkg::ST_OV]))
    else $error("overvoltage did not switch output stage off");
  fail_stays_off_a: assert property (@(posedge clk) disable iff (sys_rst) // R17
    ecc_fail |=> (od_stage_off && status_nibble[hall_dsp_pkg::ST_ECC_FAIL]) [*2])
    else $error("memory failure did not keep output stage off");

endmodule

// File: tb/mcu_receiver.sv
// Receiving controller model on the open-drain output line.
// Assumes a pull-up on the line; frames are taken on out_valid.
`timescale 1ns/1ps
module mcu_receiver (
  // Design side
  input wire logic clk,
  input wire logic [15:0] out_value,
  input wire logic [3:0] status_nibble,
  input wire logic out_valid,
  input wire logic od_stage_off,
  // Captured frame
  output logic [15:0] rx_value,
  output logic [3:0] rx_status,
  output logic line_hi
);
  // Stage off leaves only the pull-up driving the line
  assign line_hi = od_stage_off;
  always_ff @(posedge clk) begin
    if (out_valid) begin
      rx_value <= out_value;
      rx_status <= status_nibble;
    end
  end
endmodule

// File: tb/tb_hall_field_dsp_path.sv
// Self-checking bench of the field path, registers over AXI4-Lite.
// Assumes a short tick of 8 clocks and a clean parity image.
`timescale 1ns/1ps
`define CHK(n, e, s) begin comparisons++; if ((s) !== (e)) begin fails++; \
  $display("[FAIL] %s exp %0h got %0h", n, e, s); end end
module tb_hall_field_dsp_path;
  // ==========================================================================
  // Signals
  localparam logic [8:0][16:0] GOOD = {17'h0AAAA, {8{17'h10000}}};
  logic clk = 1'h0;
  logic sys_rst = 1'h1;
  logic s_axi_awvalid = 1'h0, s_axi_wvalid = 1'h0, s_axi_bready = 1'h0;
  logic s_axi_arvalid = 1'h0, s_axi_rready = 1'h0, overvoltage_in = 1'h0;
  logic [7:0] s_axi_awaddr = '0, s_axi_araddr = '0;
  logic [31:0] s_axi_wdata = '0;
  logic [3:0] s_axi_wstrb = 4'hF;
  logic signed [15:0] adc_value = '0;
  logic [8:0][16:0] eeprom_image = GOOD;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic out_valid, od_stage_off, irq, line_hi;
  logic [1:0] s_axi_bresp, s_axi_rresp, rsp;
  logic [31:0] s_axi_rdata, rd;
  logic [2:0] range_sel;
  logic [15:0] out_value, rx_value;
  logic [3:0] status_nibble, rx_status;
  int fails = 0;
  int comparisons = 0;

  hall_field_dsp_path #(.TICK_CYCLES(8)) uut (.clk, .sys_rst, .s_axi_awaddr, .s_axi_awvalid,
    .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp,
    .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
    .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .adc_value, .overvoltage_in, .range_sel,
    .eeprom_image, .out_value, .status_nibble, .out_valid, .od_stage_off, .irq);
  mcu_receiver mcu (.clk, .out_value, .status_nibble, .out_valid, .od_stage_off, .rx_value,
    .rx_status, .line_hi);

  initial forever #10 clk = ~clk;

  task automatic results;
    $display("comparisons %0d fails %0d", comparisons, fails);
    if (fails == 0 && comparisons > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask

  // Readies are comb, so they are sampled 1 ns after the edge
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    int n;
    logic ta, tw, tb;
    n = 0;
    @(posedge clk);
    s_axi_awaddr <= a; s_axi_wdata <= d;
    s_axi_awvalid <= 1'h1; s_axi_wvalid <= 1'h1; s_axi_bready <= 1'h1;
    do begin
      #1; ta = s_axi_awready; tw = s_axi_wready; tb = s_axi_bvalid; rsp = s_axi_bresp;
      @(posedge clk);
      if (ta) s_axi_awvalid <= 1'h0;
      if (tw) s_axi_wvalid <= 1'h0;
      n++;
    end while (!tb && n < 40);
    s_axi_bready <= 1'h0;
    if (!tb) begin fails++; results(); end
  endtask

  task automatic rdr(input logic [7:0] a);
    int n;
    logic ta, t;
    n = 0;
    @(posedge clk);
    s_axi_araddr <= a; s_axi_arvalid <= 1'h1; s_axi_rready <= 1'h1;
    do begin
      #1; ta = s_axi_arready; t = s_axi_rvalid; rd = s_axi_rdata; rsp = s_axi_rresp;
      @(posedge clk);
      if (ta) s_axi_arvalid <= 1'h0;
      n++;
    end while (!t && n < 40);
    s_axi_rready <= 1'h0;
    if (!t) begin fails++; results(); end
  endtask

  task automatic smp(input int k);
    int n;
    n = 0;
    while (k > 0 && n < 2000) begin @(posedge clk); #1; if (out_valid) k--; n++; end
    if (k > 0) begin fails++; results(); end
    @(posedge clk); #1;
  endtask

  // ==========================================================================
  // Scenarios
  task automatic t_regs;
    rdr(hall_dsp_pkg::SPAN_ADDR); `CHK("span", hall_dsp_pkg::SPAN_RST, rd[1:0])
    rdr(hall_dsp_pkg::GAIN_ADDR); `CHK("gain", hall_dsp_pkg::GAIN_RST, rd[14:0])
    rdr(8'h40); `CHK("unmapped", hall_dsp_pkg::RESP_SLVERR, rsp)
    wr(hall_dsp_pkg::RESULT_ADDR, 32'h0); `CHK("ro write", hall_dsp_pkg::RESP_SLVERR, rsp)
  endtask

  task automatic t_span;
    logic [2:0] ex [4] = '{3'h4, 3'h2, 3'h2, 3'h1};
    for (int i = 0; i < 4; i++) begin
      wr(hall_dsp_pkg::SPAN_ADDR, 32'(i)); `CHK("range", ex[i], range_sel)
    end
  endtask

  // Gains 1, 2, -1 and max; the negative result must floor at zero
  task automatic t_path;
    logic [14:0] g [4] = '{15'h5000, 15'h6000, 15'h3000, 15'h7FFF};
    logic [15:0] ex [4] = '{16'h044C, 16'h0834, 16'h0000, 16'h1003};
    wr(hall_dsp_pkg::SMOOTH_ADDR, 32'h7);
    wr(hall_dsp_pkg::SHIFT_ADDR, 32'h4064);
    adc_value <= 16'sh03E8;
    for (int i = 0; i < 4; i++) begin
      wr(hall_dsp_pkg::GAIN_ADDR, 32'(g[i])); smp(2);
      `CHK("value", ex[i], rx_value)
    end
    wr(hall_dsp_pkg::SHIFT_ADDR, 32'h7FFF); adc_value <= 16'sh4E20; smp(2);
    `CHK("sat", 16'hFFFF, rx_value)
  endtask

  task automatic t_filter;
    wr(hall_dsp_pkg::GAIN_ADDR, 32'h5000); wr(hall_dsp_pkg::SHIFT_ADDR, 32'h4000);
    wr(hall_dsp_pkg::SMOOTH_ADDR, 32'h6); adc_value <= 16'sh03E8; smp(80);
    `CHK("dc", 16'h03E8, rx_value)
  endtask

  task automatic t_clamp;
    wr(hall_dsp_pkg::SMOOTH_ADDR, 32'h7); wr(hall_dsp_pkg::FLOOR_ADDR, 32'h2);
    wr(hall_dsp_pkg::CEIL_ADDR, 32'h3); smp(2);
    `CHK("low", 16'h0800, rx_value)
    `CHK("clamp bit", 1'h1, rx_status[3])
    adc_value <= 16'sh1388; smp(2);
    `CHK("high", 16'h0FFF, rx_value)
  endtask

  task automatic t_diag;
    wr(hall_dsp_pkg::IRQ_MASK_ADDR, 32'h1); overvoltage_in <= 1'h1;
    repeat (3) @(posedge clk);
    #1; `CHK("ov", 1'h1, status_nibble[0])
    `CHK("ov off", 1'h1, line_hi)
    `CHK("irq", 1'h1, irq)
    @(posedge clk); overvoltage_in <= 1'h0;
    rdr(hall_dsp_pkg::IRQ_STAT_ADDR); `CHK("stat", 1'h1, rd[0])
    rdr(hall_dsp_pkg::IRQ_STAT_ADDR); `CHK("cleared", 1'h0, rd[0])
    `CHK("irq low", 1'h0, irq)
    eeprom_image <= GOOD ^ 153'h1;
    repeat (3) @(posedge clk);
    #1; `CHK("fix", 1'h1, status_nibble[1])
    `CHK("fix on", 1'h0, od_stage_off)
    @(posedge clk); eeprom_image <= GOOD ^ 153'h20001;
    repeat (3) @(posedge clk);
    #1; `CHK("fail", 1'h1, status_nibble[2])
    @(posedge clk); eeprom_image <= GOOD;
    repeat (3) @(posedge clk);
    #1; `CHK("kept off", 1'h1, od_stage_off)
    rdr(hall_dsp_pkg::DIAG_ADDR); `CHK("diag off", 1'h1, rd[11])
  endtask

  initial begin
    repeat (2) @(posedge clk);
    sys_rst <= 1'h0;
    t_regs; t_span; t_path; t_filter; t_clamp; t_diag;
    results;
  end
endmodule
